// [hw/bpec_consts.svh]
`ifndef BPEC_CONSTS_SVH
`define BPEC_CONSTS_SVH

// Register offsets
`define BPEC_REG_PRESET0     8'h00
`define BPEC_REG_PRESET1     8'h01
`define BPEC_REG_CONTROL     8'h02

// Field positions
`define BPEC_MODE_BIT        7
`define BPEC_CODE_MSB        6
`define BPEC_CTRL_DISC_BIT   0
`define BPEC_CTRL_RAMP_MSB   3
`define BPEC_CTRL_RAMP_LSB   1

// Reset values
`define BPEC_PRESET0_RST     8'h46
`define BPEC_PRESET1_RST     8'h42
`define BPEC_CONTROL_RST     8'h00
`define BPEC_DEV_ADDR        7'h2a
`define BPEC_PIN_RST         4'h3

// Timing
`define BPEC_CLK_PERIOD_PS   10000
`define BPEC_RAMP_STEP_PS    625000
`define BPEC_RAMP_STEP_CYC   ((`BPEC_RAMP_STEP_PS + `BPEC_CLK_PERIOD_PS - 1) / `BPEC_CLK_PERIOD_PS)
`define BPEC_SS_TIME_PS      1000000
`define BPEC_SS_CYC          ((`BPEC_SS_TIME_PS + `BPEC_CLK_PERIOD_PS - 1) / `BPEC_CLK_PERIOD_PS)

`endif

// [hw/bpec_pkg.sv]
package bpec_pkg;

   typedef struct packed {
      logic preset_select_pin;
      logic en;
      logic sda;
      logic scl;
   } bpec_pin_s;

   typedef enum logic [8:0] {
      I_IDLE     = 9'h001,
      I_ADDR     = 9'h002,
      I_ACK_ADDR = 9'h004,
      I_REG      = 9'h008,
      I_ACK_REG  = 9'h010,
      I_WDATA    = 9'h020,
      I_ACK_W    = 9'h040,
      I_RDATA    = 9'h080,
      I_RACK     = 9'h100
   } bpec_i2c_e;

   typedef enum logic [3:0] {
      C_OFF  = 4'h1,
      C_SOFT = 4'h2,
      C_RAMP = 4'h4,
      C_REG  = 4'h8
   } bpec_conv_e;

endpackage : bpec_pkg

// [hw/bpec_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpec_consts.svh"

// How it works
// RULE1: Enable high starts switching and regulation toward the selected preset.
// RULE2: Enable low stops regulation and returns to the disabled state.
// RULE3: Outside party keeps the enable pin at a defined level.
// RULE4: I2C accesses work regardless of the enable pin.
// RULE5: Output discharged on disable only when the discharge bit is set; clear after reset.
// RULE6: Soft start holds the lowest code, then ramps at the programmed rate.
// RULE7: Start-up never discharges, so a pre-biased output is accepted.
// RULE8: Select pin low picks preset zero, high picks preset one.
// RULE9: Outside party keeps the preset select pin at a defined level.
// RULE10: Both presets reset to power save mode, voltages per variant, rewritable.
// RULE11: Targets from 0.5 V to 1.77 V in 10 mV codes.
// RULE12: Mode bit low leaves automatic PWM and power save switching.
// RULE13: Bits 6 to 0 hold the voltage code, 500 mV plus 10 mV each.
// RULE14: Bit 7 picks forced PWM, changeable while the preset is active.
// RULE15: A write to the active preset applies when the I2C transfer ends.
module bpec_ctrl
   import bpec_pkg::*;
#(
   parameter int unsigned RAMP_BASE_CYC = `BPEC_RAMP_STEP_CYC,
   parameter int unsigned SS_CYC        = `BPEC_SS_CYC,
   parameter logic [7:0]  PRESET0_RST   = `BPEC_PRESET0_RST,
   parameter logic [7:0]  PRESET1_RST   = `BPEC_PRESET1_RST,
   parameter logic [6:0]  DEV_ADDR      = `BPEC_DEV_ADDR
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       enable_i,
   input  wire logic       preset_select_pin_i,
   output logic            switching_o,
   output logic            regulating_o,
   output logic            discharge_o,
   output logic            pwm_force_o,
   output logic [6:0]      setpoint_o
);

   function automatic logic [7:0] reg_rd(input logic [7:0] a, input logic [7:0] p0,
                                          input logic [7:0] p1, input logic [7:0] ctl);
      case (a)
         `BPEC_REG_PRESET0: reg_rd = p0;
         `BPEC_REG_PRESET1: reg_rd = p1;
         `BPEC_REG_CONTROL: reg_rd = ctl;
         default:           reg_rd = 8'h00;
      endcase
   endfunction : reg_rd

   function automatic logic [6:0] step_to(input logic [6:0] sp, input logic [6:0] tg);
      if (tg > sp) begin
         step_to = ((tg - sp) >= 7'h02) ? 7'(sp + 7'h02) : 7'(sp + 7'h01);
      end else begin
         step_to = ((sp - tg) >= 7'h02) ? 7'(sp - 7'h02) : 7'(sp - 7'h01);
      end
   endfunction : step_to

   // Pin synchronisers
   bpec_pin_s s1, s2, s3, filt, filt_d;
   bpec_pin_s next_filt;
   logic [3:0] agree;

   always_comb begin
      agree     = ~(s2 ^ s3);
      next_filt = bpec_pin_s'((s2 & agree) | (filt & ~agree));
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s1     <= bpec_pin_s'(`BPEC_PIN_RST);
         s2     <= bpec_pin_s'(`BPEC_PIN_RST);
         s3     <= bpec_pin_s'(`BPEC_PIN_RST);
         filt   <= bpec_pin_s'(`BPEC_PIN_RST);
         filt_d <= bpec_pin_s'(`BPEC_PIN_RST);
      end else begin
         s1     <= bpec_pin_s'({preset_select_pin_i, enable_i, sda_i, scl_i});
         s2     <= s1;
         s3     <= s2;
         filt   <= next_filt;
         filt_d <= filt;
      end
   end

   logic scl_rise, scl_fall, i2c_start, i2c_stop;
   assign scl_rise  = filt.scl & ~filt_d.scl;
   assign scl_fall  = ~filt.scl & filt_d.scl;
   assign i2c_start = filt.scl & filt_d.scl & filt_d.sda & ~filt.sda;
   assign i2c_stop  = filt.scl & filt_d.scl & ~filt_d.sda & filt.sda;

   // I2C slave and register file
   bpec_i2c_e  ist, next_ist;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] shreg, next_shreg, ptr, next_ptr, rd_next;
   logic       rw, next_rw, nack, next_nack, next_oe, stop_p, next_stop_p;
   logic [7:0] preset0, preset1, control;
   logic [7:0] next_preset0, next_preset1, next_control;

   always_comb begin
      next_ist     = ist;
      next_bitcnt  = bitcnt;
      next_shreg   = shreg;
      next_ptr     = ptr;
      next_rw      = rw;
      next_nack    = nack;
      next_oe      = sda_oe_o;
      next_stop_p  = 1'b0;
      next_preset0 = preset0;
      next_preset1 = preset1;
      next_control = control;
      rd_next      = reg_rd(8'(ptr + 8'h01), preset0, preset1, control);
      // Accesses served whatever the enable pin does, see RULE4
      if (i2c_start) begin
         next_ist    = I_ADDR;
         next_bitcnt = 4'h0;
         next_oe     = 1'b0;
      end else if (i2c_stop) begin
         next_ist    = I_IDLE;
         next_oe     = 1'b0;
         next_stop_p = 1'b1;
      end else if (scl_rise) begin
         if (ist == I_ADDR || ist == I_REG || ist == I_WDATA) begin
            next_shreg  = {shreg[6:0], filt.sda};
            next_bitcnt = 4'(bitcnt + 4'h1);
         end else if (ist == I_RDATA) begin
            next_bitcnt = 4'(bitcnt + 4'h1);
         end else if (ist == I_RACK) begin
            next_nack = filt.sda;
         end
      end else if (scl_fall) begin
         unique case (ist)
            I_IDLE: begin
            end
            I_ADDR: begin
               if (bitcnt == 4'h8) begin
                  if (shreg[7:1] == DEV_ADDR) begin
                     next_ist = I_ACK_ADDR;
                     next_oe  = 1'b1;
                     next_rw  = shreg[0];
                  end else begin
                     next_ist = I_IDLE;
                  end
               end
            end
            I_REG: begin
               if (bitcnt == 4'h8) begin
                  next_ptr = shreg;
                  next_ist = I_ACK_REG;
                  next_oe  = 1'b1;
               end
            end
            I_WDATA: begin
               if (bitcnt == 4'h8) begin
                  case (ptr)
                     `BPEC_REG_PRESET0: next_preset0 = shreg; // see RULE10
                     `BPEC_REG_PRESET1: next_preset1 = shreg; // see RULE10
                     `BPEC_REG_CONTROL: next_control = shreg;
                     default: begin
                     end
                  endcase
                  next_ptr = 8'(ptr + 8'h01);
                  next_ist = I_ACK_W;
                  next_oe  = 1'b1;
               end
            end
            I_ACK_ADDR: begin
               next_bitcnt = 4'h0;
               if (rw) begin
                  next_shreg = reg_rd(ptr, preset0, preset1, control);
                  next_oe    = ~next_shreg[7];
                  next_ist   = I_RDATA;
               end else begin
                  next_oe  = 1'b0;
                  next_ist = I_REG;
               end
            end
            I_ACK_REG, I_ACK_W: begin
               next_bitcnt = 4'h0;
               next_oe     = 1'b0;
               next_ist    = I_WDATA;
            end
            I_RDATA: begin
               if (bitcnt == 4'h8) begin
                  next_oe  = 1'b0;
                  next_ist = I_RACK;
               end else begin
                  next_shreg = {shreg[6:0], 1'b0};
                  next_oe    = ~shreg[6];
               end
            end
            I_RACK: begin
               if (nack) begin
                  next_ist = I_IDLE;
               end else begin
                  next_ptr    = 8'(ptr + 8'h01);
                  next_shreg  = rd_next;
                  next_oe     = ~rd_next[7];
                  next_bitcnt = 4'h0;
                  next_ist    = I_RDATA;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ist      <= I_IDLE;
         bitcnt   <= 4'h0;
         shreg    <= 8'h00;
         ptr      <= 8'h00;
         rw       <= 1'b0;
         nack     <= 1'b0;
         sda_oe_o <= 1'b0;
         sda_o    <= 1'b0;
         stop_p   <= 1'b0;
         preset0  <= PRESET0_RST; // see RULE10
         preset1  <= PRESET1_RST; // see RULE10
         control  <= `BPEC_CONTROL_RST; // see RULE5
      end else begin
         ist      <= next_ist;
         bitcnt   <= next_bitcnt;
         shreg    <= next_shreg;
         ptr      <= next_ptr;
         rw       <= next_rw;
         nack     <= next_nack;
         sda_oe_o <= next_oe;
         sda_o    <= 1'b0;
         stop_p   <= next_stop_p;
         preset0  <= next_preset0;
         preset1  <= next_preset1;
         control  <= next_control;
      end
   end

   // Converter sequencing
   bpec_conv_e  cst, next_cst;
   logic [12:0] cnt, next_cnt, interval;
   logic [7:0]  applied0, applied1, next_applied0, next_applied1, sel;
   logic [6:0]  target, next_sp;

   always_comb begin
      sel           = filt.preset_select_pin ? applied1 : applied0; // see RULE8
      target        = sel[`BPEC_CODE_MSB:0]; // see RULE11, RULE13
      interval      = 13'(RAMP_BASE_CYC) << control[`BPEC_CTRL_RAMP_MSB:`BPEC_CTRL_RAMP_LSB];
      next_applied0 = stop_p ? preset0 : applied0; // see RULE15
      next_applied1 = stop_p ? preset1 : applied1; // see RULE15
      next_cst      = cst;
      next_cnt      = cnt;
      next_sp       = setpoint_o;
      if (!filt.en) begin
         next_cst = C_OFF; // see RULE2
         next_cnt = 13'h0000;
         next_sp  = 7'h00;
      end else begin
         unique case (cst)
            C_OFF: begin
               next_cst = C_SOFT; // see RULE1
               next_cnt = 13'h0000;
            end
            C_SOFT: begin
               // Lowest code held, no discharge, see RULE6, RULE7
               if (cnt >= 13'(SS_CYC - 1)) begin
                  next_cst = C_RAMP;
                  next_cnt = 13'h0000;
               end else begin
                  next_cnt = 13'(cnt + 13'h0001);
               end
            end
            C_RAMP: begin
               if (setpoint_o == target) begin
                  next_cst = C_REG;
               end else if (cnt >= 13'(interval - 13'h0001)) begin
                  next_cnt = 13'h0000;
                  next_sp  = step_to(setpoint_o, target); // see RULE6
               end else begin
                  next_cnt = 13'(cnt + 13'h0001);
               end
            end
            C_REG: begin
               if (setpoint_o != target) begin
                  next_cst = C_RAMP;
                  next_cnt = 13'h0000;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cst          <= C_OFF;
         cnt          <= 13'h0000;
         setpoint_o   <= 7'h00;
         applied0     <= PRESET0_RST;
         applied1     <= PRESET1_RST;
         switching_o  <= 1'b0;
         regulating_o <= 1'b0;
         discharge_o  <= 1'b0;
         pwm_force_o  <= 1'b0;
      end else begin
         cst          <= next_cst;
         cnt          <= next_cnt;
         setpoint_o   <= next_sp;
         applied0     <= next_applied0;
         applied1     <= next_applied1;
         switching_o  <= (next_cst != C_OFF);
         regulating_o <= (next_cst == C_REG);
         discharge_o  <= (next_cst == C_OFF) & control[`BPEC_CTRL_DISC_BIT]; // see RULE5
         // Low leaves automatic mode change, see RULE12, RULE14
         pwm_force_o  <= (next_cst != C_OFF) & sel[`BPEC_MODE_BIT];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_en_on;
      $rose(filt.en) |=> switching_o;
   endproperty
   a_en_on: assert property (p_en_on) else $error("No switching after enable"); // see RULE1

   property p_en_off;
      !filt.en |=> !switching_o && !regulating_o;
   endproperty
   a_en_off: assert property (p_en_off) else $error("Still active while disabled"); // see RULE2

   property p_disc;
      discharge_o |-> !switching_o && $past(control[`BPEC_CTRL_DISC_BIT]);
   endproperty
   a_disc: assert property (p_disc) else $error("Discharge without bit or while on"); // see RULE5

   property p_soft;
      cst == C_SOFT |-> setpoint_o == 7'h00;
   endproperty
   a_soft: assert property (p_soft) else $error("Soft start not at lowest code"); // see RULE6

   property p_step;
      switching_o && $changed(setpoint_o) |->
         ((setpoint_o - $past(setpoint_o)) inside {7'h01, 7'h02, 7'h7e, 7'h7f});
   endproperty
   a_step: assert property (p_step) else $error("Setpoint step too large"); // see RULE6

   property p_spacing;
      cst == C_RAMP && $changed(setpoint_o) |=> $stable(setpoint_o);
   endproperty
   a_spacing: assert property (p_spacing) else $error("Ramp steps back to back"); // see RULE6

   property p_sel;
      $rose(regulating_o) |-> setpoint_o == $past(target);
   endproperty
   a_sel: assert property (p_sel) else $error("Regulating off selected target"); // see RULE8

   property p_commit;
      stop_p |=> applied0 == $past(preset0) && applied1 == $past(preset1);
   endproperty
   a_commit: assert property (p_commit) else $error("Presets not applied at stop"); // see RULE15

   property p_hold;
      !stop_p |=> $stable(applied0) && $stable(applied1);
   endproperty
   a_hold: assert property (p_hold) else $error("Presets applied mid transfer"); // see RULE15

   property p_ack;
      ist == I_ACK_ADDR |-> sda_oe_o;
   endproperty
   a_ack: assert property (p_ack) else $error("Address not acknowledged"); // see RULE4

   property p_mode;
      regulating_o |-> pwm_force_o == $past(sel[`BPEC_MODE_BIT]);
   endproperty
   a_mode: assert property (p_mode) else $error("Mode bit not followed"); // see RULE14

endmodule : bpec_ctrl
`default_nettype wire

// [bench/bpec_i2c_host.sv]
`timescale 1ns/1ps
`default_nettype none
module bpec_i2c_host #(
   parameter int unsigned Q        = 6,
   parameter logic [6:0]  DEV_ADDR = 7'h2a
) (
   input  wire logic       clk_i,
   input  wire logic       sda_i,
   output var  logic       scl_o,
   output var  logic       sda_oe_o,
   output var  logic       res_valid_o,
   output var  logic [7:0] res_data_o
);
   initial begin
      scl_o       = 1'b1;
      sda_oe_o    = 1'b0;
      res_valid_o = 1'b0;
      res_data_o  = 8'h00;
   end

   task automatic wq;
      repeat (Q) @(posedge clk_i);
   endtask : wq

   // Start or repeated start
   task automatic start_c;
      sda_oe_o <= 1'b0;
      wq();
      scl_o <= 1'b1;
      wq();
      sda_oe_o <= 1'b1;
      wq();
      scl_o <= 1'b0;
      wq();
   endtask : start_c

   task automatic stop_c;
      sda_oe_o <= 1'b1;
      wq();
      scl_o <= 1'b1;
      wq();
      sda_oe_o <= 1'b0;
      wq();
   endtask : stop_c

   task automatic clk_bit(input logic b, output logic s);
      sda_oe_o <= ~b;
      wq();
      scl_o <= 1'b1;
      wq();
      s = sda_i;
      scl_o <= 1'b0;
      wq();
   endtask : clk_bit

   task automatic send(input logic [7:0] d, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      a = ~s;
   endtask : send

   task automatic recv(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(1'b1, s);
   endtask : recv

   task automatic post(input logic [7:0] d);
      res_data_o  <= d;
      res_valid_o <= 1'b1;
      @(posedge clk_i);
      res_valid_o <= 1'b0;
   endtask : post

   task automatic write_reg(input logic [7:0] r, input logic [7:0] d);
      logic a;
      start_c();
      send({DEV_ADDR, 1'b0}, a);
      send(r, a);
      send(d, a);
      stop_c();
   endtask : write_reg

   task automatic read_reg(input logic [7:0] r);
      logic       a;
      logic [7:0] d;
      start_c();
      send({DEV_ADDR, 1'b0}, a);
      send(r, a);
      start_c();
      send({DEV_ADDR, 1'b1}, a);
      recv(d);
      stop_c();
      post(d);
   endtask : read_reg

   // Address only; reports the acknowledge
   task automatic probe(input logic [6:0] addr);
      logic a;
      start_c();
      send({addr, 1'b0}, a);
      stop_c();
      post({7'h00, a});
   endtask : probe
endmodule : bpec_i2c_host
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpec_consts.svh"
module tb;
   localparam int unsigned SS    = 8;
   localparam int unsigned RB    = 2;
   localparam int          LIMIT = 40000;
   localparam logic [7:0]  P0    = `BPEC_PRESET0_RST;
   localparam logic [7:0]  P1    = `BPEC_PRESET1_RST;

   logic       clk_i = 1'b0;
   logic       rstn_i, enable_i, preset_select_pin_i, snap;
   logic       sda_o, sda_oe_o, switching_o, regulating_o, discharge_o, pwm_force_o;
   logic [6:0] setpoint_o, tgt, prev_sp, code;
   logic       scl, h_oe, res_valid, prev_sw, run;
   logic [2:0] rc;
   logic [15:0] gap, ivl;
   logic [7:0] res_data;
   logic [7:0] tbl [2] = '{8'h7f, 8'h80};
   wire        sda_w = ~((sda_oe_o & ~sda_o) | h_oe);
   logic [7:0] exp_b [$];
   logic [10:0] exp_s [$];
   int         failures, n_compared, cycles;

   always #5 clk_i = ~clk_i;

   bpec_ctrl #(.RAMP_BASE_CYC(RB), .SS_CYC(SS)) u_bpec_ctrl (
      .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .enable_i(enable_i), .preset_select_pin_i(preset_select_pin_i),
      .switching_o(switching_o), .regulating_o(regulating_o), .discharge_o(discharge_o),
      .pwm_force_o(pwm_force_o), .setpoint_o(setpoint_o));

   bpec_i2c_host #(.DEV_ADDR(`BPEC_DEV_ADDR)) u_bpec_i2c_host (
      .clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(h_oe),
      .res_valid_o(res_valid), .res_data_o(res_data));

   task automatic complete_run;
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: byte %h expected %h", $time, g, e);
      end
   endtask : cmp_byte

   task automatic cmp_stat(input logic [10:0] e, input logic [10:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: status %h expected %h", $time, g, e);
      end
   endtask : cmp_stat

   task automatic cmp_step(input logic [6:0] e, input logic [6:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: ramp step to %h expected %h", $time, g, e);
      end
   endtask : cmp_step

   task automatic cmp_gap(input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: ramp step gap %0d expected %0d", $time, g, e);
      end
   endtask : cmp_gap

   // Two codes a step toward the target, one when a single code remains
   function automatic logic [6:0] step_to(input logic [6:0] p, input logic [6:0] t);
      if (t > p) return (t - p >= 2) ? p + 7'h02 : t;
      return (p - t >= 2) ? p - 7'h02 : t;
   endfunction : step_to

   always @(posedge clk_i) begin
      if (res_valid === 1'b1) cmp_byte(exp_b.pop_front(), res_data);
      if (snap === 1'b1) begin
         cmp_stat(exp_s.pop_front(),
                  {switching_o, regulating_o, discharge_o, pwm_force_o, setpoint_o});
      end
      if (switching_o === 1'b1 && prev_sw === 1'b1 && setpoint_o !== prev_sp) begin
         cmp_step(step_to(prev_sp, tgt), setpoint_o);
         if (run === 1'b1) cmp_gap(ivl, gap);
         run <= 1'b1;
         gap <= 16'h0001;
      end else begin
         if (regulating_o !== 1'b0 || switching_o !== 1'b1) run <= 1'b0;
         gap <= 16'(gap + 16'h0001);
      end
      prev_sw <= switching_o;
      prev_sp <= setpoint_o;
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         complete_run();
      end
   end

   task automatic chk_stat(input logic [10:0] v);
      @(posedge clk_i);
      exp_s.push_back(v);
      snap <= 1'b1;
      @(posedge clk_i);
      snap <= 1'b0;
   endtask : chk_stat

   task automatic rd(input logic [7:0] r, input logic [7:0] e);
      exp_b.push_back(e);
      u_bpec_i2c_host.read_reg(r);
   endtask : rd

   task automatic reg_to(input logic mode);
      int n;
      n = 0;
      repeat (12) @(posedge clk_i);
      while (regulating_o !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      chk_stat({3'b110, mode, tgt});
   endtask : reg_to

   task automatic go_on(input logic mode);
      int n;
      n = 0;
      enable_i <= 1'b1;
      while (switching_o !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      chk_stat({3'b100, mode, 7'h00});
   endtask : go_on

   initial begin
      rstn_i              = 1'b0;
      enable_i            = 1'b0;
      preset_select_pin_i = 1'b0;
      snap                = 1'b0;
      prev_sw             = 1'b0;
      prev_sp             = 7'h00;
      run                 = 1'b0;
      rc                  = 3'h0;
      gap                 = 16'h0000;
      ivl                 = 16'(RB);
      tgt                 = P0[6:0];
      failures            = 0;
      n_compared          = 0;
      cycles              = 0;
      void'($urandom(26));
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk_stat(11'h000);
      rd(`BPEC_REG_PRESET0, P0);
      rd(`BPEC_REG_PRESET1, P1);
      rd(`BPEC_REG_CONTROL, `BPEC_CONTROL_RST);
      rd(8'h03, 8'h00);
      exp_b.push_back(8'h00);
      u_bpec_i2c_host.probe(`BPEC_DEV_ADDR ^ 7'h01);
      exp_b.push_back(8'h01);
      u_bpec_i2c_host.probe(`BPEC_DEV_ADDR);
      go_on(1'b0);
      reg_to(1'b0);
      tgt = P1[6:0];
      preset_select_pin_i <= 1'b1;
      reg_to(1'b0);
      code = 7'($urandom_range(127, 0));
      tgt = code;
      u_bpec_i2c_host.write_reg(`BPEC_REG_PRESET1, {1'b1, code});
      reg_to(1'b1);
      rd(`BPEC_REG_PRESET1, {1'b1, code});
      for (int i = 0; i < 2; i++) begin
         tgt = tbl[i][6:0];
         u_bpec_i2c_host.write_reg(`BPEC_REG_PRESET0, tbl[i]);
         preset_select_pin_i <= 1'b0;
         reg_to(tbl[i][7]);
      end
      enable_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_stat(11'h000);
      rc  = 3'($urandom_range(3, 1));
      tgt = 7'h30;
      u_bpec_i2c_host.write_reg(`BPEC_REG_CONTROL, {4'h0, rc, 1'b1});
      u_bpec_i2c_host.write_reg(`BPEC_REG_PRESET0, {1'b1, tgt});
      rd(`BPEC_REG_CONTROL, {4'h0, rc, 1'b1});
      ivl = 16'(RB << rc);
      go_on(1'b1);
      reg_to(1'b1);
      enable_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk_stat(11'h100);
      complete_run();
   end
endmodule : tb
`default_nettype wire
